// ==== shared/strap_cfg_pkg.sv ====
// shared constants for the strap latch, decode and general purpose pin block
package strap_cfg_pkg;

  // number of downstream ports that have disable, fixed and charging straps
  localparam int unsigned PORT_COUNT = 6;

  // sensed resistor level index presented by the analog strap sensor
  localparam logic [2:0] LVL_WEAK_PD   = 3'h0;
  localparam logic [2:0] LVL_WEAK_PU   = 3'h1;
  localparam logic [2:0] LVL_MEDIUM_PD = 3'h2;
  localparam logic [2:0] LVL_MEDIUM_PU = 3'h3;
  localparam logic [2:0] LVL_STRONG_PD = 3'h4;
  localparam logic [2:0] LVL_STRONG_PU = 3'h5;

  // management serial role decoded from the operating-mode strap
  typedef enum logic [1:0] {
    MODE_BRIDGE_MASTER = 2'b00,
    MODE_CONFIG_SLAVE  = 2'b01,
    MODE_RESERVED      = 2'b10
  } mode_e;

  // register byte offsets
  localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
  localparam logic [7:0] OFS_PORT_STATUS  = 8'h04;
  localparam logic [7:0] OFS_GPIO_DIR     = 8'h08;
  localparam logic [7:0] OFS_GPIO_OUT     = 8'h0C;
  localparam logic [7:0] OFS_GPIO_PULL_EN = 8'h10;
  localparam logic [7:0] OFS_GPIO_PULL_UP = 8'h14;
  localparam logic [7:0] OFS_GPIO_IN      = 8'h18;

  // field positions in the strap status word
  localparam int unsigned POS_MODE_LVL  = 0;
  localparam int unsigned POS_FIXED_LVL = 4;
  localparam int unsigned POS_CHG_LVL   = 8;
  localparam int unsigned POS_ROLE      = 12;
  localparam int unsigned POS_VALID     = 16;

  // field positions in the port status word
  localparam int unsigned POS_PORT_DIS  = 0;
  localparam int unsigned POS_NON_REM   = 8;
  localparam int unsigned POS_CHARGE    = 16;
  localparam int unsigned POS_SS_DIS    = 24;

  // values after reset
  localparam logic [2:0]  RST_LEVEL     = 3'h0;
  localparam logic [31:0] RST_GPIO_REG  = 32'h0000_0000;
  localparam logic [31:0] RST_PRDATA    = 32'h0000_0000;

endpackage : strap_cfg_pkg

// ==== hdl/gpio_pin_cell.sv ====
// one general purpose pin: direction, drive level, input pulls and input capture
`timescale 1ns/1ns
module gpio_pin_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic dir_out,
  input  wire logic out_val,
  input  wire logic pull_en,
  input  wire logic pull_up,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_n,
  output logic      pad_pd_en,
  output logic      pad_pu_en,
  output logic      in_q
);

  // output drives low or high, enable is active low
  always_comb
  begin
    pad_out  = out_val;
    pad_oe_n = ~dir_out;
  end

  // pulls only apply to an input; a driven pin never fights its own pull
  always_comb
  begin
    pad_pd_en = ~dir_out & pull_en & ~pull_up;
    pad_pu_en = ~dir_out & pull_en & pull_up;
  end

  // pin level as seen by software, registered once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_q <= 1'b0;
    end
    else
    begin
      in_q <= pad_in;
    end
  end

endmodule : gpio_pin_cell

// ==== hdl/strap_latch_decode.sv ====
// strap capture at reset release, default setting decode and gpio control registers
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module strap_latch_decode #(
  parameter int unsigned GPIO_COUNT = 8,
  parameter int unsigned ADDR_W     = 8
) (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   chip_reset_n,
  input  wire logic                                   hub_enumerated,
  input  wire logic [2:0]                             cfg_mode_level,
  input  wire logic [strap_cfg_pkg::PORT_COUNT-1:0]   port_dplus_disable_straps,
  input  wire logic [strap_cfg_pkg::PORT_COUNT-1:0]   port_dminus_disable_straps,
  input  wire logic [2:0]                             fixed_port_count_strap,
  input  wire logic [2:0]                             charging_ports_strap,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [ADDR_W-1:0]                      paddr,
  input  wire logic [31:0]                            pwdata,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic                                   fc_wr_valid,
  output logic                                        fc_wr_ready,
  input  wire logic [ADDR_W-1:0]                      fc_wr_addr,
  input  wire logic [31:0]                            fc_wr_data,
  output logic                                        straps_valid,
  output logic                                        bridge_master_setting,
  output logic                                        config_slave_setting,
  output logic                                        mode_reserved,
  output logic      [strap_cfg_pkg::PORT_COUNT-1:0]   port_disable,
  output logic      [strap_cfg_pkg::PORT_COUNT-1:0]   ss_port_disable,
  output logic      [strap_cfg_pkg::PORT_COUNT-1:0]   non_removable,
  output logic      [strap_cfg_pkg::PORT_COUNT-1:0]   charging_enable,
  input  wire logic [GPIO_COUNT-1:0]                  general_purpose_pin_in,
  output logic      [GPIO_COUNT-1:0]                  general_purpose_pin_out,
  output logic      [GPIO_COUNT-1:0]                  general_purpose_pin_oe_n,
  output logic      [GPIO_COUNT-1:0]                  general_purpose_pin_pd_en,
  output logic      [GPIO_COUNT-1:0]                  general_purpose_pin_pu_en
);

  localparam int unsigned NP = strap_cfg_pkg::PORT_COUNT;
  localparam int unsigned GPAD = 32 - GPIO_COUNT; // GPIO_COUNT must stay below 32

  // level index to management serial role; levels 6 and 7 cannot be sensed
  function automatic strap_cfg_pkg::mode_e role_of(input logic [2:0] lvl);
    role_of = strap_cfg_pkg::MODE_RESERVED;
    if (lvl == strap_cfg_pkg::LVL_WEAK_PD)
      role_of = strap_cfg_pkg::MODE_BRIDGE_MASTER;
    else if (lvl == strap_cfg_pkg::LVL_WEAK_PU)
      role_of = strap_cfg_pkg::MODE_CONFIG_SLAVE;
  endfunction : role_of

  // fixed-port level to port set, bit 0 is port 1 which is never fixed
  function automatic logic [NP-1:0] fixed_set(input logic [2:0] lvl);
    case (lvl)
      strap_cfg_pkg::LVL_WEAK_PD:   fixed_set = 6'h00;
      strap_cfg_pkg::LVL_WEAK_PU:   fixed_set = 6'h02;
      strap_cfg_pkg::LVL_MEDIUM_PD: fixed_set = 6'h06;
      strap_cfg_pkg::LVL_MEDIUM_PU: fixed_set = 6'h0E;
      strap_cfg_pkg::LVL_STRONG_PD: fixed_set = 6'h1E;
      strap_cfg_pkg::LVL_STRONG_PU: fixed_set = 6'h3E;
      default:                      fixed_set = 6'h00;
    endcase
  endfunction : fixed_set

  // charging level to port set; the top level jumps from 1-4 straight to 1-6
  function automatic logic [NP-1:0] charge_set(input logic [2:0] lvl);
    case (lvl)
      strap_cfg_pkg::LVL_WEAK_PD:   charge_set = 6'h00;
      strap_cfg_pkg::LVL_WEAK_PU:   charge_set = 6'h01;
      strap_cfg_pkg::LVL_MEDIUM_PD: charge_set = 6'h03;
      strap_cfg_pkg::LVL_MEDIUM_PU: charge_set = 6'h07;
      strap_cfg_pkg::LVL_STRONG_PD: charge_set = 6'h0F;
      strap_cfg_pkg::LVL_STRONG_PU: charge_set = 6'h3F;
      default:                      charge_set = 6'h00;
    endcase
  endfunction : charge_set

  logic                  rst_prev_q;
  logic                  capture;
  logic [2:0]            mode_lvl_q;
  logic [2:0]            fixed_lvl_q;
  logic [2:0]            chg_lvl_q;
  logic [NP-1:0]         dplus_q;
  logic [NP-1:0]         dminus_q;
  strap_cfg_pkg::mode_e  role_q;
  logic                  valid_q;
  logic                  master_q;
  logic                  slave_q;
  logic                  reserved_q;
  logic [NP-1:0]         port_dis_q;
  logic [NP-1:0]         non_rem_q;
  logic [NP-1:0]         charge_q;
  logic [GPIO_COUNT-1:0] dir_q;
  logic [GPIO_COUNT-1:0] out_q;
  logic [GPIO_COUNT-1:0] pull_en_q;
  logic [GPIO_COUNT-1:0] pull_up_q;
  logic [GPIO_COUNT-1:0] pin_in;
  logic [31:0]           prdata_q;
  logic [31:0]           rd_word;
  logic                  rd_hit;
  logic                  apb_setup;
  logic                  apb_access;
  logic                  apb_wr;
  logic                  wr_en;
  logic [ADDR_W-1:0]     wr_addr;
  logic [GPIO_COUNT-1:0] wr_bits;

  // previous chip reset level; starts low so power-on release also captures
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_prev_q <= 1'b0;
    else
      rst_prev_q <= chip_reset_n;
  end

  assign capture = chip_reset_n & ~rst_prev_q;

  // raw strap capture, taken once per reset release and held afterwards
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_lvl_q  <= strap_cfg_pkg::RST_LEVEL;
      fixed_lvl_q <= strap_cfg_pkg::RST_LEVEL;
      chg_lvl_q   <= strap_cfg_pkg::RST_LEVEL;
      dplus_q     <= '0;
      dminus_q    <= '0;
    end
    else if (capture)
    begin
      mode_lvl_q  <= cfg_mode_level;
      fixed_lvl_q <= fixed_port_count_strap;
      chg_lvl_q   <= charging_ports_strap;
      dplus_q     <= port_dplus_disable_straps;
      dminus_q    <= port_dminus_disable_straps;
    end
  end

  // decoded defaults; standby clears them all and sets role_q to reserved, while the raw strap levels survive it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      valid_q    <= 1'b0;
      role_q     <= strap_cfg_pkg::MODE_RESERVED;
      master_q   <= 1'b0;
      slave_q    <= 1'b0;
      reserved_q <= 1'b0;
      port_dis_q <= '0;
      non_rem_q  <= '0;
      charge_q   <= '0;
    end
    else if (!chip_reset_n)
    begin
      valid_q    <= 1'b0;
      role_q     <= strap_cfg_pkg::MODE_RESERVED;
      master_q   <= 1'b0;
      slave_q    <= 1'b0;
      reserved_q <= 1'b0;
      port_dis_q <= '0;
      non_rem_q  <= '0;
      charge_q   <= '0;
    end
    else if (capture)
    begin
      valid_q    <= 1'b1;
      role_q     <= role_of(cfg_mode_level);
      master_q   <= role_of(cfg_mode_level) == strap_cfg_pkg::MODE_BRIDGE_MASTER;
      slave_q    <= role_of(cfg_mode_level) == strap_cfg_pkg::MODE_CONFIG_SLAVE;
      reserved_q <= role_of(cfg_mode_level) == strap_cfg_pkg::MODE_RESERVED;
      port_dis_q <= port_dplus_disable_straps & port_dminus_disable_straps;
      non_rem_q  <= fixed_set(fixed_port_count_strap);
      charge_q   <= charge_set(charging_ports_strap);
    end
  end

  assign straps_valid          = valid_q;
  assign bridge_master_setting = master_q;
  assign config_slave_setting  = slave_q;
  assign mode_reserved         = reserved_q;
  assign port_disable          = port_dis_q;
  assign ss_port_disable       = port_dis_q;
  assign non_removable         = non_rem_q;
  assign charging_enable       = charge_q;

  // apb phases; zero wait states, so pready never stalls the master
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign pready     = 1'b1;

  // read mux and address decode
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr == ADDR_W'(strap_cfg_pkg::OFS_STRAP_STATUS))
    begin
      rd_word[strap_cfg_pkg::POS_MODE_LVL +: 3]  = mode_lvl_q;
      rd_word[strap_cfg_pkg::POS_FIXED_LVL +: 3] = fixed_lvl_q;
      rd_word[strap_cfg_pkg::POS_CHG_LVL +: 3]   = chg_lvl_q;
      rd_word[strap_cfg_pkg::POS_ROLE +: 2]      = role_q;
      rd_word[strap_cfg_pkg::POS_VALID]          = valid_q;
    end
    else if (paddr == ADDR_W'(strap_cfg_pkg::OFS_PORT_STATUS))
    begin
      rd_word[strap_cfg_pkg::POS_PORT_DIS +: NP] = port_dis_q;
      rd_word[strap_cfg_pkg::POS_NON_REM +: NP]  = non_rem_q;
      rd_word[strap_cfg_pkg::POS_CHARGE +: NP]   = charge_q;
      rd_word[strap_cfg_pkg::POS_SS_DIS +: NP]   = port_dis_q;
    end
    else if (paddr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_DIR))
      rd_word = {{GPAD{1'b0}}, dir_q};
    else if (paddr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_OUT))
      rd_word = {{GPAD{1'b0}}, out_q};
    else if (paddr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_PULL_EN))
      rd_word = {{GPAD{1'b0}}, pull_en_q};
    else if (paddr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_PULL_UP))
      rd_word = {{GPAD{1'b0}}, pull_up_q};
    else if (paddr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_IN))
      rd_word = {{GPAD{1'b0}}, pin_in};
    else
      rd_hit = 1'b0;
  end

  // read data registered in the setup phase, stable through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= strap_cfg_pkg::RST_PRDATA;
    else if (apb_setup)
      prdata_q <= rd_word;
  end

  assign prdata  = prdata_q;
  assign pslverr = apb_access & ~rd_hit;

  // two write paths; the serial slave wins a tie, the bridge waits on ready
  assign apb_wr      = apb_access & pwrite & rd_hit;
  assign fc_wr_ready = chip_reset_n & hub_enumerated & ~(apb_access & pwrite);
  assign wr_en       = apb_wr | (fc_wr_valid & fc_wr_ready);
  assign wr_addr     = apb_wr ? paddr : fc_wr_addr;
  assign wr_bits     = apb_wr ? pwdata[GPIO_COUNT-1:0] : fc_wr_data[GPIO_COUNT-1:0];

  // pin control registers; back to defaults while the chip sits in standby
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q     <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
      out_q     <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
      pull_en_q <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
      pull_up_q <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
    end
    else if (!chip_reset_n)
    begin
      dir_q     <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
      out_q     <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
      pull_en_q <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
      pull_up_q <= strap_cfg_pkg::RST_GPIO_REG[GPIO_COUNT-1:0];
    end
    else if (wr_en)
    begin
      if (wr_addr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_DIR))
        dir_q <= wr_bits;
      else if (wr_addr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_OUT))
        out_q <= wr_bits;
      else if (wr_addr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_PULL_EN))
        pull_en_q <= wr_bits;
      else if (wr_addr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_PULL_UP))
        pull_up_q <= wr_bits;
    end
  end

  // one pin cell per general purpose pin
  for (genvar g = 0; g < GPIO_COUNT; g++)
  begin : g_pin
    gpio_pin_cell u_cell (
      .pclk      (pclk),
      .presetn   (presetn),
      .dir_out   (dir_q[g]),
      .out_val   (out_q[g]),
      .pull_en   (pull_en_q[g]),
      .pull_up   (pull_up_q[g]),
      .pad_in    (general_purpose_pin_in[g]),
      .pad_out   (general_purpose_pin_out[g]),
      .pad_oe_n  (general_purpose_pin_oe_n[g]),
      .pad_pd_en (general_purpose_pin_pd_en[g]),
      .pad_pu_en (general_purpose_pin_pu_en[g]),
      .in_q      (pin_in[g])
    );
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // capture on release takes the mode strap and raises valid one edge later
  chk_capture_on_release: assert property (
    (chip_reset_n && !rst_prev_q) |=> (straps_valid && mode_lvl_q == $past(cfg_mode_level)))
    else $error("strap capture missed a reset release");
  // settings hold while valid, whatever the strap pins do
  chk_hold_after_capture: assert property (
    (straps_valid && $past(straps_valid)) |->
      ($stable(port_disable) && $stable(non_removable) && $stable(charging_enable)
       && $stable(bridge_master_setting)))
    else $error("latched settings changed after capture");
  // weak pull-down selects bridging master
  chk_master_mode: assert property (
    (chip_reset_n && !rst_prev_q && cfg_mode_level == strap_cfg_pkg::LVL_WEAK_PD)
      |=> (bridge_master_setting && !config_slave_setting))
    else $error("weak pull-down did not select master role");
  // weak pull-up selects configuration slave
  chk_slave_mode: assert property (
    (chip_reset_n && !rst_prev_q && cfg_mode_level == strap_cfg_pkg::LVL_WEAK_PU)
      |=> (config_slave_setting && !bridge_master_setting))
    else $error("weak pull-up did not select slave role");
  // exactly one role once valid, reserved for the six upper levels 2 to 7
  chk_one_role: assert property (
    straps_valid |-> $onehot({bridge_master_setting, config_slave_setting, mode_reserved}))
    else $error("decoded role is not one-hot");
  // a port needs both of its disable straps high
  chk_both_straps: assert property (
    straps_valid |-> (port_disable == (dplus_q & dminus_q)))
    else $error("port disable does not match both straps");
  // superspeed partner is off exactly when both legacy straps were high at capture
  chk_ss_follows: assert property (
    (chip_reset_n && !rst_prev_q) |=> (ss_port_disable ==
      ($past(port_dplus_disable_straps) & $past(port_dminus_disable_straps))))
    else $error("superspeed disable differs from legacy disable");
  // port 1 is never reported as fixed
  chk_fixed_port_one: assert property (
    (chip_reset_n && !rst_prev_q) |=>
      (!non_removable[0] && non_removable == fixed_set($past(fixed_port_count_strap))))
    else $error("fixed port set wrong");
  // ports 5 and 6 only ever charge together
  chk_charge_pair: assert property (
    charging_enable[4] == charging_enable[5])
    else $error("charging ports 5 and 6 split");
  // a direction write from the serial slave turns the pin driver on next edge
  chk_dir_write: assert property (
    (apb_access && pwrite && chip_reset_n && paddr == ADDR_W'(strap_cfg_pkg::OFS_GPIO_DIR)
     && pwdata[0]) |=> !general_purpose_pin_oe_n[0])
    else $error("direction write did not enable the driver");
  // a driven pin carries no pull
  chk_no_pull_driven: assert property (
    !general_purpose_pin_oe_n[0] |->
      (!general_purpose_pin_pd_en[0] && !general_purpose_pin_pu_en[0]))
    else $error("pull applied to a driven pin");

endmodule : strap_latch_decode

// ==== dv/strap_board_model.sv ====
// board strap resistors and the external chip reset source
`timescale 1ns/1ns
module strap_board_model (
  input  wire logic       pclk,
  input  wire logic       rst_req,
  input  wire logic [2:0] mode_sel,
  input  wire logic [2:0] fixed_sel,
  input  wire logic [2:0] chg_sel,
  input  wire logic [5:0] off_req,
  input  wire logic [5:0] half_req,
  output logic            chip_reset_n,
  output logic      [2:0] cfg_mode_level,
  output logic      [2:0] fixed_port_count_strap,
  output logic      [2:0] charging_ports_strap,
  output logic      [5:0] port_dplus_disable_straps,
  output logic      [5:0] port_dminus_disable_straps
);
  // reset source is released at power-up, so power-on alone must capture
  always @(posedge pclk) chip_reset_n <= !rst_req;
  // resistors sensed as a level index, static on the board
  assign cfg_mode_level         = mode_sel;
  assign fixed_port_count_strap = fixed_sel;
  assign charging_ports_strap   = chg_sel;
  // a port is strapped off with both lines high; half_req ties d-plus only
  assign port_dplus_disable_straps  = off_req | half_req;
  assign port_dminus_disable_straps = off_req;
endmodule : strap_board_model

// ==== dv/strap_latch_decode_tb_top.sv ====
// self-checking bench for strap capture, decode and pin registers
`timescale 1ns/1ns
module strap_latch_decode_tb_top;
  logic        pclk, presetn, hub_enumerated, psel, penable, pwrite, pready, pslverr, er;
  logic        fc_wr_valid, fc_wr_ready, straps_valid, bridge_master_setting, rst_req;
  logic        config_slave_setting, mode_reserved, chip_reset_n;
  logic [2:0]  cfg_mode_level, fixed_port_count_strap, charging_ports_strap;
  logic [2:0]  mode_sel, fixed_sel, chg_sel;
  logic [5:0]  port_dplus_disable_straps, port_dminus_disable_straps, off_req, half_req;
  logic [5:0]  port_disable, ss_port_disable, non_removable, charging_enable;
  logic [7:0]  paddr, fc_wr_addr, general_purpose_pin_in, general_purpose_pin_out;
  logic [7:0]  general_purpose_pin_oe_n, general_purpose_pin_pd_en, general_purpose_pin_pu_en;
  logic [7:0]  dir, ov, pe, pu;
  logic [31:0] pwdata, prdata, fc_wr_data, rd;
  int          n_mismatch = 0;
  int          tests_run = 0;

  strap_board_model board (.pclk, .rst_req, .mode_sel, .fixed_sel, .chg_sel, .off_req,
    .half_req, .chip_reset_n, .cfg_mode_level, .fixed_port_count_strap,
    .charging_ports_strap, .port_dplus_disable_straps, .port_dminus_disable_straps);
  strap_latch_decode #(.GPIO_COUNT(8), .ADDR_W(8)) DUT (.pclk, .presetn, .chip_reset_n,
    .hub_enumerated, .cfg_mode_level, .port_dplus_disable_straps, .port_dminus_disable_straps,
    .fixed_port_count_strap, .charging_ports_strap, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fc_wr_valid, .fc_wr_ready, .fc_wr_addr, .fc_wr_data,
    .straps_valid, .bridge_master_setting, .config_slave_setting, .mode_reserved,
    .port_disable, .ss_port_disable, .non_removable, .charging_enable,
    .general_purpose_pin_in, .general_purpose_pin_out, .general_purpose_pin_oe_n,
    .general_purpose_pin_pd_en, .general_purpose_pin_pu_en);

  // 125 MHz core clock
  initial
  begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // apb master: request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // host bridging write, valid held until ready is seen
  task automatic fc_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    fc_wr_valid <= 1'h1;
    fc_wr_addr  <= a;
    fc_wr_data  <= d;
    do
      @(posedge pclk);
    while (fc_wr_ready !== 1'h1);
    fc_wr_valid <= 1'h0;
  endtask : fc_write

  function automatic logic [5:0] fixed_set(input logic [2:0] l);
    return (l == 3'h0 || l > 3'h5) ? 6'h00 : 6'(((1 << l) - 1) << 1);
  endfunction : fixed_set

  function automatic logic [5:0] chg_set(input logic [2:0] l);
    return (l == 3'h5) ? 6'h3F : (l > 3'h5) ? 6'h00 : 6'((1 << l) - 1);
  endfunction : chg_set

  task automatic chk_decode(input logic [2:0] m, f, c, input logic [5:0] off);
    chk("valid", 1, straps_valid);
    chk("master", m == 3'h0, bridge_master_setting);
    chk("slave", m == 3'h1, config_slave_setting);
    chk("reserved", m > 3'h1, mode_reserved);
    chk("port off", off, port_disable);
    chk("ss off", off, ss_port_disable);
    chk("fixed", fixed_set(f), non_removable);
    chk("charge", chg_set(c), charging_enable);
  endtask : chk_decode

  // standby, capture on chip reset rise, then straps move and must be ignored
  task automatic capture(input logic [2:0] m, f, c, input logic [5:0] off, half);
    @(posedge pclk);
    rst_req   <= 1'h1;
    mode_sel  <= m;
    fixed_sel <= f;
    chg_sel   <= c;
    off_req   <= off;
    half_req  <= half;
    repeat (4) @(posedge pclk);
    #1 chk("standby", 0, {straps_valid, port_disable});
    @(posedge pclk);
    rst_req <= 1'h0;
    for (int n = 0; n < 20 && straps_valid !== 1'h1; n++)
      @(posedge pclk);
    #1 chk_decode(m, f, c, off);
    @(posedge pclk);
    mode_sel <= m ^ 3'h1;
    off_req  <= ~off;
    chg_sel  <= 3'h5 - c;
    repeat (3) @(posedge pclk);
    #1 chk_decode(m, f, c, off);
    apb(1'h0, strap_cfg_pkg::OFS_PORT_STATUS, 32'h0);
    chk("port status", {2'h0, off, 2'h0, chg_set(c), 2'h0, fixed_set(f), 2'h0, off}, rd);
    apb(1'h0, strap_cfg_pkg::OFS_STRAP_STATUS, 32'h0);
    chk("strap status", {15'h0, 1'h1, 2'h0, ((m > 3'h1) ? 2'h2 : m[1:0]), 1'h0, c, 1'h0, f,
        1'h0, m}, rd);
  endtask : capture

  // watchdog far beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    presetn = 1'h0;
    hub_enumerated = 1'h1;
    {psel, penable, pwrite, paddr, pwdata, rst_req} = '0;
    {fc_wr_valid, fc_wr_addr, fc_wr_data, general_purpose_pin_in} = '0;
    {mode_sel, fixed_sel, chg_sel, off_req, half_req} = {3'h1, 3'h5, 3'h5, 6'h21, 6'h02};
    rd = $urandom(32'h46A81667);
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    // power-on capture with chip reset already high; d-plus only on port 2
    repeat (3) @(posedge pclk);
    #1 chk_decode(3'h1, 3'h5, 3'h5, 6'h21);
    chk("pins idle", 8'hFF, general_purpose_pin_oe_n);
    apb(1'h0, strap_cfg_pkg::OFS_GPIO_DIR, 32'h0);
    chk("dir reset", strap_cfg_pkg::RST_GPIO_REG, rd);
    // every level of every strap, random port straps, all ports off once
    for (int i = 0; i < 6; i++)
      capture(3'(i), 3'((i + 2) % 6), 3'((i + 4) % 6), (i == 5) ? 6'h3F : 6'($urandom),
              6'($urandom));
    // levels that cannot be sensed fall back to reserved role and empty sets
    capture(3'h7, 3'h6, 3'h7, 6'($urandom), 6'($urandom));
    // pin settings by apb and by host bridging
    for (int i = 0; i < 4; i++)
    begin
      dir = 8'($urandom);
      ov = 8'($urandom);
      pe = 8'($urandom);
      pu = 8'($urandom);
      apb(1'h1, strap_cfg_pkg::OFS_GPIO_DIR, {24'h0, dir});
      apb(1'h1, strap_cfg_pkg::OFS_GPIO_PULL_EN, {24'h0, pe});
      apb(1'h1, strap_cfg_pkg::OFS_GPIO_PULL_UP, {24'h0, pu});
      fc_write(strap_cfg_pkg::OFS_GPIO_OUT, {24'h0, ov});
      general_purpose_pin_in <= ov ^ dir;
      @(posedge pclk);
      #1 chk("oe_n", {24'h0, ~dir}, general_purpose_pin_oe_n);
      chk("out", ov, general_purpose_pin_out);
      chk("pd", {24'h0, pe & ~pu & ~dir}, general_purpose_pin_pd_en);
      chk("pu", {24'h0, pe & pu & ~dir}, general_purpose_pin_pu_en);
      apb(1'h0, strap_cfg_pkg::OFS_GPIO_IN, 32'h0);
      chk("pin in", {24'h0, ov ^ dir}, rd);
    end
    // bridging is shut while not enumerated; unmapped address errors
    hub_enumerated <= 1'h0;
    @(posedge pclk);
    #1 chk("fc ready", 0, fc_wr_ready);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 1, er);
    complete_run();
  end
endmodule : strap_latch_decode_tb_top
